/* src/mpr_readout_defs.vh */
// Constants for the pattern-readout command interpreter
`ifndef MPR_READOUT_DEFS_VH
`define MPR_READOUT_DEFS_VH
`define CMD_NOP        3'h7
`define CMD_MRS        3'h0
`define CMD_REF        3'h1
`define CMD_PRE        3'h2
`define CMD_ACT        3'h3
`define CMD_WR         3'h4
`define CMD_RD         3'h5
`define MR3_SEL        3'h3
`define MR_EN_BIT      2
`define MR_AP_BIT      10
`define MR_BC_BIT      12
`define PATTERN_BL8    8'hAA
`define PATTERN_RFU    8'h00
`define BEATS_BL8      4'h8
`define BEATS_BC4      4'h4
`define SYNC_FILL      3'h5
`define MR_LOC_HI      1
`define MR_LOC_LO      0
`define COL_NIBBLE_BIT 2
`endif

/* src/mpr_sync3.v */
// Three-stage synchroniser with agreement check
`timescale 1ns/1ps
`default_nettype none
module mpr_sync3 #(
	parameter W = 1
) (
	// Clock and reset
	input  wire         ref_clk,
	input  wire         rst_n,
	// Data
	input  wire [W-1:0] async_in,
	output reg  [W-1:0] sync_out
);
	reg [W-1:0] s1_q;
	reg [W-1:0] s2_q;
	reg [W-1:0] s3_q;
	integer i;
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_q     <= {W{1'b0}};
			s2_q     <= {W{1'b0}};
			s3_q     <= {W{1'b0}};
			sync_out <= {W{1'b0}};
		end else begin
			s1_q <= async_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
			for (i = 0; i < W; i = i + 1) begin
				if (s2_q[i] == s3_q[i]) begin
					sync_out[i] <= s3_q[i];
				end
			end
		end
	end
endmodule
`default_nettype wire

/* src/mpr_fifo.v */
// Synchronous FIFO with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module mpr_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 32,
	parameter AW    = 5
) (
	// Clock and reset
	input  wire             ref_clk,
	input  wire             rst_n,
	// Write side
	input  wire             in_valid,
	output wire             in_ready,
	input  wire [WIDTH-1:0] in_data,
	// Read side
	output wire             out_valid,
	input  wire             out_ready,
	output wire [WIDTH-1:0] out_data
);
	reg [WIDTH-1:0] mem_q [0:DEPTH-1];
	reg [AW-1:0]    wp_q;
	reg [AW-1:0]    rp_q;
	reg [AW:0]      cnt_q;
	wire            push;
	wire            pop;
	assign in_ready  = (cnt_q != DEPTH[AW:0]);
	assign out_valid = (cnt_q != {(AW+1){1'b0}});
	assign out_data  = mem_q[rp_q];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;
	always @(posedge ref_clk) begin
		if (push) begin
			mem_q[wp_q] <= in_data;
		end
	end
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			wp_q  <= {AW{1'b0}};
			rp_q  <= {AW{1'b0}};
			cnt_q <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wp_q <= (wp_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_q + 1'b1;
			end
			if (pop) begin
				rp_q <= (rp_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp_q + 1'b1;
			end
			if (push && !pop) begin
				cnt_q <= cnt_q + 1'b1;
			end else if (pop && !push) begin
				cnt_q <= cnt_q - 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

/* src/mpr_readout.v */
// Pattern-readout command interpreter of a DDR3-class memory
`include "mpr_readout_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module mpr_readout #(
	parameter DEPTH = 32
) (
	// Clock and reset
	input  wire        ref_clk,
	input  wire        rst_n,
	// Command pins from controller
	input  wire        ck_pin,
	input  wire        cs_n_pin,
	input  wire        ras_n_pin,
	input  wire        cas_n_pin,
	input  wire        we_n_pin,
	input  wire [2:0]  ba_pin,
	input  wire [13:0] addr_pin,
	input  wire        bc4_mode,
	// Read data stream out
	output reg         rd_valid,
	input  wire        rd_ready,
	output reg  [15:0] rd_data,
	output reg         rd_last,
	// Array routing and status
	output reg         arr_rd,
	output reg         arr_wr,
	output reg         arr_ap,
	output reg         mpr_active,
	output reg         illegal_cmd,
	output reg  [1:0]  pattern_location_select,
	output reg         cmd_stall
);
	// ==========================================================
	// Local constants
	localparam MODE_NORMAL  = 1'b0;
	localparam MODE_PATTERN = 1'b1;
	localparam BURST_IDLE   = 1'b0;
	localparam BURST_FILL   = 1'b1;
	localparam SW           = 22;

	// ==========================================================
	// Decode functions
	// Command code, deselect reads as no operation
	function [2:0] cmd_code;
		input       cs_n;
		input [2:0] rcw;
		begin
			cmd_code = cs_n ? `CMD_NOP : rcw;
		end
	endfunction

	// Chopped burst: fixed by mode pin, or A12 low on the fly
	function chop_sel;
		input fixed_bc4;
		input a12;
		begin
			chop_sel = fixed_bc4 | ~a12;
		end
	endfunction

	// First beat: upper nibble for a chopped read with A2 high
	function [2:0] first_beat;
		input chop;
		input a2;
		begin
			first_beat = chop ? {a2, 2'h0} : 3'h0;
		end
	endfunction

	// Beats in one burst
	function [3:0] burst_len;
		input chop;
		begin
			burst_len = chop ? `BEATS_BC4 : `BEATS_BL8;
		end
	endfunction

	// Pattern bit of one beat, beat zero in the lowest bit
	function pat_bit;
		input [1:0] loc;
		input [2:0] beat;
		reg   [7:0] p;
		begin
			p       = (loc == 2'h0) ? `PATTERN_BL8 : `PATTERN_RFU;
			pat_bit = p[beat];
		end
	endfunction

	// ==========================================================
	// Pin synchronisation
	wire          ck_s;
	wire          cs_n_s;
	wire          ras_n_s;
	wire          cas_n_s;
	wire          we_n_s;
	wire [2:0]    ba_s;
	wire [13:0]   a_s;
	wire [SW-1:0] pins_raw;
	wire [SW-1:0] pins_s;
	assign pins_raw = {ck_pin, cs_n_pin, ras_n_pin, cas_n_pin, we_n_pin,
		ba_pin, addr_pin};
	mpr_sync3 #(.W(SW)) u_sync (
		.ref_clk  (ref_clk),
		.rst_n    (rst_n),
		.async_in (pins_raw),
		.sync_out (pins_s)
	);
	assign ck_s    = pins_s[21];
	assign cs_n_s  = pins_s[20];
	assign ras_n_s = pins_s[19];
	assign cas_n_s = pins_s[18];
	assign we_n_s  = pins_s[17];
	assign ba_s    = pins_s[16:14];
	assign a_s     = pins_s[13:0];

	// ==========================================================
	// CK edge detection and command decode
	reg  [2:0]  warm_q;
	reg         ck_prev_q;
	wire        warm;
	wire        ck_rise;
	wire [2:0]  cmd;
	wire        cmd_mrs_mr3;
	wire        cmd_rd;
	wire        cmd_wr;
	// Edges count once the synchroniser holds real pin values
	assign warm        = (warm_q == `SYNC_FILL);
	assign ck_rise     = warm & ck_s & ~ck_prev_q;
	assign cmd         = cmd_code(cs_n_s, {ras_n_s, cas_n_s, we_n_s});
	assign cmd_mrs_mr3 = (cmd == `CMD_MRS) && (ba_s == `MR3_SEL);
	assign cmd_rd      = (cmd == `CMD_RD);
	assign cmd_wr      = (cmd == `CMD_WR);
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			warm_q    <= 3'h0;
			ck_prev_q <= 1'b0;
		end else begin
			ck_prev_q <= ck_s;
			if (!warm) begin
				warm_q <= warm_q + 3'h1;
			end
		end
	end

	// ==========================================================
	// Mode state
	reg         mode_q;
	reg         mode_d;
	reg  [1:0]  loc_q;
	reg  [1:0]  loc_d;
	always @* begin
		mode_d = mode_q;
		loc_d  = loc_q;
		if (ck_rise && cmd_mrs_mr3) begin
			mode_d = a_s[`MR_EN_BIT];
			loc_d  = a_s[`MR_LOC_HI:`MR_LOC_LO];
		end
	end

	// ==========================================================
	// Burst generation
	reg         burst_q;
	reg         burst_d;
	reg  [3:0]  left_q;
	reg  [3:0]  left_d;
	reg  [2:0]  beat_q;
	reg  [2:0]  beat_d;
	wire        chop_rd;
	wire        rd_take;
	wire        push;
	wire        f_ready;
	assign chop_rd = chop_sel(bc4_mode, a_s[`MR_BC_BIT]);
	assign rd_take = ck_rise && (mode_q == MODE_PATTERN) && cmd_rd;
	assign push    = (burst_q == BURST_FILL);
	always @* begin
		burst_d = burst_q;
		left_d  = left_q;
		beat_d  = beat_q;
		case (burst_q)
		BURST_IDLE: begin
			if (rd_take) begin
				beat_d  = first_beat(chop_rd,
					a_s[`COL_NIBBLE_BIT]);
				left_d  = burst_len(chop_rd);
				burst_d = BURST_FILL;
			end
		end
		BURST_FILL: begin
			if (f_ready) begin
				left_d = left_q - 4'h1;
				beat_d = beat_q + 3'h1;
				if (left_q == 4'h1) begin
					burst_d = BURST_IDLE;
				end
			end
		end
		default: begin
			burst_d = BURST_IDLE;
		end
		endcase
	end

	// ==========================================================
	// Command checks and array routing
	reg         ill_d;
	reg         arr_rd_d;
	reg         arr_wr_d;
	reg         arr_ap_d;
	always @* begin
		ill_d    = 1'b0;
		arr_rd_d = 1'b0;
		arr_wr_d = 1'b0;
		arr_ap_d = 1'b0;
		if (ck_rise && !cmd_mrs_mr3) begin
			case (mode_q)
			MODE_PATTERN: begin
				// Command other than read, no operation or MR3 mode-register set flagged
				ill_d = !cmd_rd && (cmd != `CMD_NOP);
			end
			MODE_NORMAL: begin
				arr_rd_d = cmd_rd;
				arr_wr_d = cmd_wr;
				arr_ap_d = (cmd_rd | cmd_wr) & a_s[`MR_AP_BIT];
			end
			default: begin
				ill_d = 1'b0;
			end
			endcase
		end
	end

	// ==========================================================
	// State registers
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_q      <= MODE_NORMAL;
			loc_q       <= 2'h0;
			burst_q     <= BURST_IDLE;
			left_q      <= 4'h0;
			beat_q      <= 3'h0;
			arr_rd      <= 1'b0;
			arr_wr      <= 1'b0;
			arr_ap      <= 1'b0;
			illegal_cmd <= 1'b0;
		end else begin
			mode_q      <= mode_d;
			loc_q       <= loc_d;
			burst_q     <= burst_d;
			left_q      <= left_d;
			beat_q      <= beat_d;
			arr_rd      <= arr_rd_d;
			arr_wr      <= arr_wr_d;
			arr_ap      <= arr_ap_d;
			illegal_cmd <= ill_d;
		end
	end

	// ==========================================================
	// Output buffer
	wire        pb;
	wire [15:0] word;
	wire [16:0] f_in;
	wire        f_valid;
	wire [16:0] f_data;
	wire        f_out_ready;
	assign pb          = pat_bit(loc_q, beat_q);
	// pattern bit copied across both byte lanes
	assign word        = {{8{pb}}, {8{pb}}};
	assign f_in        = {left_q == 4'h1, word};
	assign f_out_ready = ~rd_valid | rd_ready;
	mpr_fifo #(.WIDTH(17), .DEPTH(DEPTH), .AW(5)) u_fifo (
		.ref_clk   (ref_clk),
		.rst_n     (rst_n),
		.in_valid  (push),
		.in_ready  (f_ready),
		.in_data   (f_in),
		.out_valid (f_valid),
		.out_ready (f_out_ready),
		.out_data  (f_data)
	);

	// ==========================================================
	// Output register stage
	reg         rd_valid_d;
	reg  [15:0] rd_data_d;
	reg         rd_last_d;
	always @* begin
		rd_valid_d = rd_valid;
		rd_data_d  = rd_data;
		rd_last_d  = rd_last;
		if (f_out_ready) begin
			rd_valid_d = f_valid;
			rd_last_d  = f_data[16] & f_valid;
			if (f_valid) begin
				rd_data_d = f_data[15:0];
			end
		end
	end
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_valid                <= 1'b0;
			rd_data                 <= 16'h0000;
			rd_last                 <= 1'b0;
			mpr_active              <= 1'b0;
			pattern_location_select <= 2'h0;
			cmd_stall               <= 1'b0;
		end else begin
			rd_valid                <= rd_valid_d;
			rd_data                 <= rd_data_d;
			rd_last                 <= rd_last_d;
			mpr_active              <= mode_q;
			pattern_location_select <= loc_q;
			cmd_stall               <= ~f_ready;
		end
	end
endmodule
`default_nettype wire

/* testbench/mpr_ctrl_model.sv */
// Controller model driving command pins on its own CK
`timescale 1ns/1ps
`default_nettype none
module mpr_ctrl_model (
	// Command pins
	output var logic        ck_pin,
	output var logic        cs_n_pin,
	output var logic        ras_n_pin,
	output var logic        cas_n_pin,
	output var logic        we_n_pin,
	output var logic [2:0]  ba_pin,
	output var logic [13:0] addr_pin
);
	initial begin
		ck_pin = 1'b0;
		cs_n_pin = 1'b1;
		{ras_n_pin, cas_n_pin, we_n_pin} = 3'h7;
		ba_pin = 3'h0;
		addr_pin = 14'h0000;
		#1.3;
		forever #80 ck_pin = ~ck_pin;
	end
	task automatic issue(input logic [2:0] c, input logic [2:0] b,
		input logic [13:0] a);
		@(negedge ck_pin);
		cs_n_pin = 1'b0;
		{ras_n_pin, cas_n_pin, we_n_pin} = c;
		ba_pin = b;
		addr_pin = a;
		@(negedge ck_pin);
		cs_n_pin = 1'b1;
		{ras_n_pin, cas_n_pin, we_n_pin} = ~c;
		ba_pin = ~b;
		addr_pin = ~a;
	endtask
endmodule
`default_nettype wire

/* testbench/mpr_readout_checker.sv */
// Assertions on the pattern-readout ports
`timescale 1ns/1ps
`default_nettype none
module mpr_readout_checker (
	// Clock and reset
	input wire logic        ref_clk,
	input wire logic        rst_n,
	// Observed ports
	input wire logic        rd_valid,
	input wire logic        rd_ready,
	input wire logic [15:0] rd_data,
	input wire logic        rd_last,
	input wire logic        arr_rd,
	input wire logic        arr_ap,
	input wire logic        mpr_active,
	input wire logic        illegal_cmd,
	input wire logic [1:0]  pattern_location_select
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	logic mid_q;
	logic prev_q;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			mid_q <= 1'b0;
			prev_q <= 1'b0;
		end else if (rd_valid && rd_ready) begin
			mid_q <= !rd_last;
			prev_q <= rd_data[0];
		end
	end
	sequence s_wait; rd_valid && !rd_ready; endsequence
	sequence s_beat; rd_valid && pattern_location_select == 2'h0; endsequence
	a_ap_ignored: assert property (mpr_active |-> !arr_ap)
		else $error("auto-precharge in pattern mode");
	a_no_array: assert property (mpr_active |-> !arr_rd)
		else $error("array read in pattern mode");
	a_lane_copy: assert property (rd_valid |->
		rd_data == 16'h0000 || rd_data == 16'hFFFF)
		else $error("lanes differ");
	a_rfu_zero: assert property (rd_valid &&
		pattern_location_select != 2'h0 |-> rd_data == 16'h0000)
		else $error("reserved location not zero");
	a_alt_seq: assert property (s_beat ##0 mid_q |->
		rd_data[0] != prev_q)
		else $error("pattern not alternating");
	a_first_zero: assert property (s_beat ##0 !mid_q |->
		!rd_data[0])
		else $error("first beat not zero");
	a_hold_beat: assert property (s_wait |=>
		rd_valid && $stable(rd_data))
		else $error("beat dropped while stalled");
	a_illegal_mode: assert property (illegal_cmd |-> mpr_active)
		else $error("illegal flag outside pattern mode");
endmodule
bind mpr_readout mpr_readout_checker chk_u (.ref_clk(ref_clk),
	.rst_n(rst_n), .rd_valid(rd_valid), .rd_ready(rd_ready),
	.rd_data(rd_data), .rd_last(rd_last), .arr_rd(arr_rd),
	.arr_ap(arr_ap), .mpr_active(mpr_active),
	.illegal_cmd(illegal_cmd),
	.pattern_location_select(pattern_location_select));
`default_nettype wire

/* testbench/mpr_readout_tb.sv */
// Self-checking bench for the pattern-readout block
`include "mpr_readout_defs.vh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e, m) begin checks_done++; if ((a) !== (e)) begin \
	n_errors++; $display("FAIL %0t %s", $time, m); end end
module mpr_readout_tb;
	logic        ref_clk, rst_n, ck, cs_n, ras_n, cas_n, we_n, bc4, rdy;
	logic        vld, last, ard, awr, aap, act, ill, stall;
	logic [2:0]  ba;
	logic [13:0] addr;
	logic [15:0] dat;
	logic [1:0]  loc;
	logic [3:0]  seen;
	int          n_errors, checks_done;
	mpr_ctrl_model ctl_u (.ck_pin(ck), .cs_n_pin(cs_n), .ras_n_pin(ras_n),
		.cas_n_pin(cas_n), .we_n_pin(we_n), .ba_pin(ba), .addr_pin(addr));
	mpr_readout dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .ck_pin(ck),
		.cs_n_pin(cs_n), .ras_n_pin(ras_n), .cas_n_pin(cas_n),
		.we_n_pin(we_n), .ba_pin(ba), .addr_pin(addr), .bc4_mode(bc4),
		.rd_valid(vld), .rd_ready(rdy), .rd_data(dat), .rd_last(last),
		.arr_rd(ard), .arr_wr(awr), .arr_ap(aap), .mpr_active(act),
		.illegal_cmd(ill), .pattern_location_select(loc),
		.cmd_stall(stall));
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) seen <= seen | {ill, aap, awr, ard};
	task automatic clk_n(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task automatic end_of_test();
		if (n_errors == 0 && checks_done > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic cmd(input logic [2:0] c, input logic [13:0] a,
		input logic [3:0] e);
		seen <= 4'h0;
		ctl_u.issue(c, 3'h3, a);
		clk_n(8);
		`CHK(seen, e, "pulses")
	endtask
	task automatic rx(input int n, input logic z);
		for (int i = 0; i < n; i++) begin
			for (int t = 0; vld !== 1'b1; t++) begin
				if (t > 300) begin n_errors++; end_of_test(); end
				clk_n(1);
			end
			if (i == 0) clk_n(3);
			`CHK(dat, (z || !i[0]) ? 16'h0000 : 16'hFFFF, "data")
			`CHK(last, i == n - 1, "last")
			`CHK(stall, 1'b0, "stall")
			rdy = 1'b1;
			clk_n(1);
		end
		rdy = 1'b0;
	endtask
	task automatic t_normal();
		cmd(`CMD_RD, 14'h0400, 4'h5);
		cmd(`CMD_WR, 14'h0000, 4'h2);
	endtask
	task automatic t_enter();
		cmd(`CMD_PRE, 14'h0400, 4'h0);
		cmd(`CMD_MRS, 14'h0004, 4'h0);
		`CHK(act, 1'b1, "mode on")
		`CHK(loc, 2'h0, "location")
	endtask
	task automatic t_bursts();
		// reads while mode is on, then a write that must flag illegal
		cmd(`CMD_RD, 14'h1400, 4'h0);
		rx(8, 1'b0);
		cmd(`CMD_RD, 14'h0004, 4'h0);
		rx(4, 1'b0);
		bc4 = 1'b1;
		cmd(`CMD_RD, 14'h1000, 4'h0);
		rx(4, 1'b0);
		bc4 = 1'b0;
		cmd(`CMD_WR, 14'h0000, 4'h8);
	endtask
	task automatic t_rfu();
		for (int l = 1; l < 4; l++) begin
			cmd(`CMD_MRS, 14'h0004 | l[1:0], 4'h0);
			`CHK(loc, l[1:0], "location")
			cmd(`CMD_RD, 14'h1000, 4'h0);
			rx(8, 1'b1);
		end
	endtask
	task automatic t_reset();
		rst_n = 1'b0;
		clk_n(2);
		`CHK(act, 1'b0, "reset")
		`CHK(loc, 2'h0, "reset location")
		rst_n = 1'b1;
		clk_n(8);
	endtask
	task automatic t_exit();
		t_enter();
		cmd(`CMD_MRS, 14'h0000, 4'h0);
		`CHK(act, 1'b0, "mode off")
		cmd(`CMD_RD, 14'h0000, 4'h1);
	endtask
	initial begin
		rst_n = 1'b0;
		bc4 = 1'b0;
		rdy = 1'b0;
		seen = 4'h0;
		n_errors = 0;
		checks_done = 0;
		repeat (16) @(posedge ref_clk);
		#1 rst_n = 1'b1;
		clk_n(8);
		t_normal();
		t_enter();
		t_bursts();
		t_rfu();
		t_reset();
		t_exit();
		end_of_test();
	end
endmodule
`default_nettype wire
